// *** src/fpmc_pkg.sv ***
// Functional notes
// - pin pulses pick link: 0 UART, 8/11 serial.
// - UART bit timing taken from reset command.
// - 153600 bps refused at slow peripheral clock.
// - every command answered by ACK or NAK.
// - batch verify compares whole flash with data.
// - batch erase clears the entire flash.
// - blank check reports whole flash erased or not.
// - high-speed write: address, count, write, verify.
// - successive write continues after previous write, verify or blank check.
// - setting commands and status read accepted.
// - signature command returns identification byte.
// - reset command returns engine to idle.
// - low mode bits select self-programming mode.
// - mode 11 settable by firmware only.
// - reset value 08H user, 0CH on-board.
// - bit 3 inhibits write and erase.
// - bit 2 read-only mirror of enable pin.
// - write/erase only with inhibit 0, pin 1.
// - mode register written only via protect sequence.
// - key A5H, value, inverse, value; last counts.
// - bad sequence keeps register, sets sticky error.
`default_nettype none
package fpmc_pkg;
  // ==========================================
  // register map, byte address = 4 * index
  localparam logic [15:0] IDX_KEY  = 16'hFFC0;
  localparam logic [15:0] IDX_STAT = 16'hFFC2;
  localparam logic [15:0] IDX_MPC  = 16'hFFC4;
  localparam logic [15:0] IDX_SET  = 16'hFFC6;
  localparam logic [15:0] IDX_LINK = 16'hFFC8;
  localparam int unsigned AXI_AW   = 18;
  localparam logic [7:0]  PROT_KEY = 8'hA5;
  localparam int unsigned B_INHIB  = 3;
  localparam int unsigned B_PIN    = 2;
  localparam int unsigned B_ERR    = 0;
  localparam logic [1:0]  MODE_NORM = 2'h0;
  localparam logic [1:0]  MODE_FW   = 2'h3;
  localparam logic [1:0]  MODE_BAD  = 2'h2;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;
  // ==========================================
  // link selection and timing
  localparam logic [3:0]  PULSE_CSI  = 4'h8;
  localparam logic [3:0]  PULSE_CSIH = 4'hB;
  localparam int unsigned SLOW_KHZ   = 2500;
  localparam logic [7:0]  BAUD_TOP   = 8'h05;
  localparam logic [7:0]  ERASED     = 8'hFF;
  // ==========================================
  // command codes
  localparam logic [7:0] C_RESET  = 8'h00;
  localparam logic [7:0] C_VERIFY = 8'h13;
  localparam logic [7:0] C_ERASE  = 8'h20;
  localparam logic [7:0] C_BLANK  = 8'h32;
  localparam logic [7:0] C_WRITE  = 8'h40;
  localparam logic [7:0] C_SUCC   = 8'h44;
  localparam logic [7:0] C_STATUS = 8'h70;
  localparam logic [7:0] C_OSC    = 8'h90;
  localparam logic [7:0] C_ETIME  = 8'h95;
  localparam logic [7:0] C_WTIME  = 8'h96;
  localparam logic [7:0] C_BAUD   = 8'h9A;
  localparam logic [7:0] C_SIG    = 8'hC0;
  typedef enum logic [1:0] {LNK_UART = 2'b00, LNK_CSI = 2'b01,
                            LNK_CSIH = 2'b10, LNK_BAD = 2'b11} fpmc_link_t;
  typedef enum logic [1:0] {FL_READ = 2'b00, FL_WRITE = 2'b01,
                            FL_ERASE = 2'b10} fpmc_flop_t;
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_DATA = 2'b01,
                            E_RD = 2'b10, E_BUSY = 2'b11} fpmc_eng_t;
  typedef enum logic [1:0] {K_VER = 2'b00, K_BLK = 2'b01,
                            K_WR = 2'b10} fpmc_kind_t;
  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_KEY = 2'b01,
                            PS_VAL = 2'b10, PS_INV = 2'b11} fpmc_ps_t;
endpackage
`default_nettype wire

// *** src/fpmc_protect.sv ***
`default_nettype none
module fpmc_protect
  import fpmc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       st_valid,
  input  wire logic       st_key,
  input  wire logic       st_mpc,
  input  wire logic [7:0] st_data,
  output logic            commit,
  output logic [7:0]      commit_data,
  output logic            seq_err
);
  import fpmc_pkg::*;
  fpmc_ps_t   ps_r;
  fpmc_ps_t   ps_nxt;
  logic [7:0] val_r;
  assign commit_data = val_r;
  // ==========================================
  // store sequence checker
  always_comb begin
    ps_nxt  = ps_r;
    commit  = 1'b0;
    seq_err = 1'b0;
    if (st_valid) begin
      unique case (ps_r)
        PS_IDLE: begin
          if (st_key && st_data == PROT_KEY) ps_nxt = PS_KEY;
          else if (st_key || st_mpc) seq_err = 1'b1;
        end
        PS_KEY: begin
          ps_nxt = st_mpc ? PS_VAL : PS_IDLE;
          seq_err = !st_mpc;
        end
        PS_VAL: begin
          ps_nxt = (st_mpc && st_data == ~val_r) ? PS_INV : PS_IDLE;
          seq_err = !(st_mpc && st_data == ~val_r);
        end
        PS_INV: begin
          ps_nxt  = PS_IDLE;
          commit  = st_mpc && st_data == val_r;
          seq_err = !(st_mpc && st_data == val_r);
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) ps_r <= PS_IDLE;
    else ps_r <= ps_nxt;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) val_r <= 8'h00;
    else if (st_valid && ps_r == PS_KEY && st_mpc) val_r <= st_data;
  end
endmodule
`default_nettype wire

// *** src/fpmc_pulse.sv ***
`default_nettype none
module fpmc_pulse
  import fpmc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin,
  input  wire logic close,
  output fpmc_link_t link_mode,
  output logic      link_done
);
  import fpmc_pkg::*;
  logic [3:0] cnt_r;
  logic       pin_q_r;
  logic       done_r;
  // ==========================================
  // count enable-pin pulses until first command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r   <= 4'h0;
      pin_q_r <= 1'b1;
      done_r  <= 1'b0;
    end else begin
      pin_q_r <= pin;
      if (close) done_r <= 1'b1;
      if (!done_r && pin && !pin_q_r && cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
    end
  end
  always_comb begin
    unique case (cnt_r)
      4'h0:       link_mode = LNK_UART;
      PULSE_CSI:  link_mode = LNK_CSI;
      PULSE_CSIH: link_mode = LNK_CSIH;
      default:    link_mode = LNK_BAD;
    endcase
  end
  assign link_done = done_r;
endmodule
`default_nettype wire

// *** src/fpmc_top.sv ***
`default_nettype none
module fpmc_top
  import fpmc_pkg::*;
#(
  parameter int unsigned FLASH_AW   = 16,
  parameter int unsigned PERIPH_KHZ = 8000,
  parameter logic [7:0]  SIG_BYTE   = 8'h5A // arbitrary value
)(
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                program_enable_pin,
  input  wire logic                fw_active,
  input  wire logic                rx_fall,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [FLASH_AW-1:0] cmd_addr,
  input  wire logic [FLASH_AW:0]   cmd_len,
  input  wire logic [7:0]          cmd_data,
  input  wire logic                dat_valid,
  output logic                     dat_ready,
  input  wire logic [7:0]          dat_byte,
  output logic                     rsp_valid,
  output logic                     rsp_ack,
  output logic [7:0]               rsp_data,
  output logic                     fl_req,
  output fpmc_flop_t               fl_op,
  output logic [FLASH_AW-1:0]      fl_addr,
  output logic [7:0]               fl_wdata,
  input  wire logic [7:0]          fl_rdata,
  input  wire logic                fl_ack,
  output logic                     flash_wr_enable,
  output logic [1:0]               self_mode,
  output fpmc_link_t               link_mode,
  output logic [15:0]              bit_period
);
  import fpmc_pkg::*;
  localparam logic [FLASH_AW:0] FLASH_N = (FLASH_AW+1)'(1) << FLASH_AW;
  localparam logic SLOW_CLK = PERIPH_KHZ <= SLOW_KHZ;

  function automatic logic [15:0] idx_of(input logic [AXI_AW-1:0] a);
    idx_of = a[AXI_AW-1:2];
  endfunction

  // ==========================================
  // register bus
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic       wr_go;
  logic       rd_go;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic       w_map;
  logic       st_valid;
  logic       inhibit_r;
  logic [1:0] mode_r;
  logic       err_r;
  logic [7:0] mpc_rd;
  logic       commit;
  logic [7:0] commit_data;
  logic       seq_err;
  logic [7:0] osc_r;
  logic [7:0] etime_r;
  logic [7:0] wtime_r;
  logic [7:0] baud_r;
  fpmc_eng_t  st_r;
  logic       link_done;

  assign widx  = idx_of(s_axi_awaddr);
  assign ridx  = idx_of(s_axi_araddr);
  assign w_map = widx == IDX_KEY || widx == IDX_STAT || widx == IDX_MPC
              || widx == IDX_SET || widx == IDX_LINK;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign st_valid = wr_go && w_map && s_axi_wstrb[0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_map ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rvalid_r <= 1'b0;
      rresp_r  <= AXI_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= AXI_OKAY;
      unique case (ridx)
        IDX_STAT: rdata_r <= {31'h0000_0000, err_r};
        IDX_MPC:  rdata_r <= {24'h00_0000, mpc_rd};
        IDX_SET:  rdata_r <= {baud_r, wtime_r, etime_r, osc_r};
        IDX_LINK: rdata_r <= {bit_period, 10'h000, st_r, link_done,
                              flash_wr_enable, link_mode};
        IDX_KEY:  rdata_r <= 32'h0000_0000;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // protected mode control register
  fpmc_protect u_protect (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .st_valid    (st_valid),
    .st_key      (widx == IDX_KEY),
    .st_mpc      (widx == IDX_MPC),
    .st_data     (s_axi_wdata[7:0]),
    .commit      (commit),
    .commit_data (commit_data),
    .seq_err     (seq_err)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inhibit_r <= 1'b1;
      mode_r    <= MODE_NORM;
    end else if (commit) begin
      inhibit_r <= commit_data[B_INHIB];
      if (commit_data[1:0] != MODE_BAD
          && (commit_data[1:0] != MODE_FW || fw_active)) begin
        mode_r <= commit_data[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) err_r <= 1'b0;
    else if (seq_err) err_r <= 1'b1;
    else if (st_valid && widx == IDX_STAT && !s_axi_wdata[B_ERR]) err_r <= 1'b0;
  end

  // bit 2 follows the pin, so reset reads 08H or 0CH
  assign mpc_rd = {4'h0, inhibit_r, program_enable_pin, mode_r};
  assign flash_wr_enable = !inhibit_r && program_enable_pin;
  assign self_mode = mode_r;

  // ==========================================
  // link selection and UART timing
  fpmc_pulse u_pulse (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin       (program_enable_pin),
    .close     (cmd_valid),
    .link_mode (link_mode),
    .link_done (link_done)
  );

  logic [15:0] meas_r;
  logic [15:0] last_r;
  logic        synced_r;
  logic        cmd_go;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meas_r     <= 16'h0000;
      last_r     <= 16'h0000;
      synced_r   <= 1'b0;
      bit_period <= 16'h0000;
    end else begin
      meas_r <= rx_fall ? 16'h0001 : (meas_r == 16'hFFFF ? meas_r : meas_r + 16'h0001);
      if (rx_fall && !synced_r) last_r <= meas_r;
      if (cmd_go && cmd_code == C_RESET && !synced_r && link_mode == LNK_UART) begin
        synced_r   <= 1'b1;
        bit_period <= last_r;
      end
    end
  end

  // ==========================================
  // command engine
  fpmc_kind_t          kind_r;
  logic [FLASH_AW-1:0] addr_r;
  logic [FLASH_AW-1:0] next_r;
  logic [FLASH_AW:0]   cnt_r;
  logic [7:0]          byte_r;
  logic                ok_r;
  logic                last_byte;
  logic                match;

  assign cmd_ready = st_r == E_IDLE || cmd_code == C_RESET;
  assign cmd_go    = cmd_valid && cmd_ready;
  assign dat_ready = st_r == E_DATA;
  assign last_byte = cnt_r == (FLASH_AW+1)'(1);
  assign match = fl_rdata == (kind_r == K_BLK ? ERASED : byte_r);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r      <= E_IDLE;
      kind_r    <= K_VER;
      addr_r    <= '0;
      next_r    <= '0;
      cnt_r     <= '0;
      byte_r    <= 8'h00;
      ok_r      <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_ack   <= 1'b0;
      rsp_data  <= 8'h00;
      fl_req    <= 1'b0;
      fl_op     <= FL_READ;
      fl_addr   <= '0;
      fl_wdata  <= 8'h00;
      osc_r     <= 8'h00;
      etime_r   <= 8'h00;
      wtime_r   <= 8'h00;
      baud_r    <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_go) begin
        rsp_valid <= 1'b1;
        rsp_ack   <= 1'b1;
        rsp_data  <= 8'h00;
        ok_r      <= 1'b1;
        st_r      <= E_IDLE;
        fl_req    <= 1'b0;
        unique case (cmd_code)
          C_RESET: ;
          C_VERIFY: begin
            rsp_valid <= 1'b0;
            kind_r    <= K_VER;
            addr_r    <= '0;
            cnt_r     <= FLASH_N;
            st_r      <= E_DATA;
          end
          C_ERASE: begin
            if (flash_wr_enable) begin
              rsp_valid <= 1'b0;
              fl_req    <= 1'b1;
              fl_op     <= FL_ERASE;
              st_r      <= E_BUSY;
            end else begin
              rsp_ack <= 1'b0;
            end
          end
          C_BLANK: begin
            rsp_valid <= 1'b0;
            kind_r    <= K_BLK;
            addr_r    <= '0;
            cnt_r     <= FLASH_N;
            fl_req    <= 1'b1;
            fl_op     <= FL_READ;
            fl_addr   <= '0;
            st_r      <= E_RD;
          end
          C_WRITE, C_SUCC: begin
            if (flash_wr_enable && cmd_len != '0) begin
              rsp_valid <= 1'b0;
              kind_r    <= K_WR;
              addr_r    <= cmd_code == C_WRITE ? cmd_addr : next_r;
              cnt_r     <= cmd_len;
              st_r      <= E_DATA;
            end else begin
              rsp_ack <= 1'b0;
            end
          end
          C_STATUS: rsp_data <= {st_r, synced_r, link_done, flash_wr_enable,
                                 err_r, link_mode};
          C_OSC:   osc_r <= cmd_data;
          C_ETIME: etime_r <= cmd_data;
          C_WTIME: wtime_r <= cmd_data;
          C_BAUD: begin
            if (cmd_data > BAUD_TOP || (cmd_data == BAUD_TOP && SLOW_CLK)) begin
              rsp_ack <= 1'b0;
            end else begin
              baud_r <= cmd_data;
            end
          end
          C_SIG: rsp_data <= SIG_BYTE;
          default: rsp_ack <= 1'b0;
        endcase
      end else begin
        unique case (st_r)
          E_IDLE: ;
          E_DATA: begin
            if (dat_valid) begin
              byte_r  <= dat_byte;
              fl_req  <= 1'b1;
              fl_addr <= addr_r;
              if (kind_r == K_WR && !flash_wr_enable) begin
                fl_req    <= 1'b0;
                rsp_valid <= 1'b1;
                rsp_ack   <= 1'b0;
                st_r      <= E_IDLE;
              end else if (kind_r == K_WR) begin
                fl_op    <= FL_WRITE;
                fl_wdata <= dat_byte;
                st_r     <= E_BUSY;
              end else begin
                fl_op <= FL_READ;
                st_r  <= E_RD;
              end
            end
          end
          E_BUSY: begin
            if (fl_ack && fl_op == FL_ERASE) begin
              fl_req    <= 1'b0;
              rsp_valid <= 1'b1;
              rsp_ack   <= 1'b1;
              st_r      <= E_IDLE;
            end else if (fl_ack) begin
              fl_op <= FL_READ;
              st_r  <= E_RD;
            end
          end
          E_RD: begin
            if (fl_ack) begin
              ok_r    <= ok_r && match;
              addr_r  <= addr_r + 1'b1;
              next_r  <= addr_r + 1'b1;
              cnt_r   <= cnt_r - 1'b1;
              fl_addr <= addr_r + 1'b1;
              fl_req  <= 1'b0;
              if (last_byte) begin
                rsp_valid <= 1'b1;
                rsp_ack   <= ok_r && match;
                st_r      <= E_IDLE;
              end else if (kind_r == K_BLK) begin
                fl_req <= 1'b1;
              end else begin
                st_r <= E_DATA;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // checks
  a_fw_mode_only: assert property (@(posedge clk_sys) disable iff (srst)
    mode_r == MODE_FW && $past(mode_r) != MODE_FW |-> $past(fw_active))
    else $error("firmware mode set without firmware");
  a_high_bits_zero: assert property (@(posedge clk_sys) disable iff (srst)
    mpc_rd[7:4] == 4'h0 && mode_r != MODE_BAD)
    else $error("mode register high bits or mode bad");
  a_pin_mirror: assert property (@(posedge clk_sys) disable iff (srst)
    rd_go && ridx == IDX_MPC |=> s_axi_rdata[B_PIN] == $past(program_enable_pin))
    else $error("pin mirror bit wrong");
  a_write_gate: assert property (@(posedge clk_sys) disable iff (srst)
    fl_req && fl_op != FL_READ |-> !inhibit_r && program_enable_pin)
    else $error("flash write while blocked");
  a_mpc_guarded: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(inhibit_r) || $changed(mode_r) |-> $past(commit))
    else $error("mode register changed outside sequence");
  a_err_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    err_r && !(st_valid && widx == IDX_STAT && !s_axi_wdata[0]) |=> err_r)
    else $error("error flag lost");
  a_err_set: assert property (@(posedge clk_sys) disable iff (srst)
    seq_err |=> err_r && $stable(inhibit_r) && $stable(mode_r))
    else $error("bad sequence not flagged");
  a_reset_cmd: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_valid && cmd_code == C_RESET |=> rsp_valid && rsp_ack && st_r == E_IDLE)
    else $error("reset command not handled");
  a_baud_slow: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_go && cmd_code == C_BAUD && cmd_data == BAUD_TOP && SLOW_CLK
    |=> rsp_valid && !rsp_ack)
    else $error("top baud accepted at slow clock");
  a_sig_reply: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_go && cmd_code == C_SIG |=> rsp_valid && rsp_ack && rsp_data == SIG_BYTE)
    else $error("signature reply wrong");
  a_reset_value: assert property (@(posedge clk_sys) disable iff (srst)
    $past(srst) |-> mpc_rd == {4'h0, 1'b1, program_enable_pin, MODE_NORM})
    else $error("mode register reset value wrong");
  c_commit: cover property (@(posedge clk_sys) disable iff (srst) commit);
  c_seq_err: cover property (@(posedge clk_sys) disable iff (srst) seq_err);
  c_write_done: cover property (@(posedge clk_sys) disable iff (srst)
    rsp_valid && rsp_ack && kind_r == K_WR);
endmodule
`default_nettype wire

// *** tb/fpmc_flash_model.sv ***
`default_nettype none
module fpmc_flash_model
  import fpmc_pkg::*;
#(
  parameter int unsigned AW = 4
)(
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          fl_req,
  input  wire fpmc_flop_t    fl_op,
  input  wire logic [AW-1:0] fl_addr,
  input  wire logic [7:0]    fl_wdata,
  output logic [7:0]         fl_rdata,
  output logic               fl_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [2**AW];
  logic [2:0] cnt;
  logic       slow;
  // ====
  // array, prompt and slow answers in turn
  always_ff @(posedge clk_sys) begin
    fl_ack <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (srst) begin
      cnt <= 3'h0;
      slow <= 1'b0;
      fl_rdata <= 8'h00;
      for (int i = 0; i < 2**AW; i++) mem[i] <= 8'h00;
    end else if (fl_req && !fl_ack) begin
      cnt <= cnt + 3'h1;
      if (cnt == (slow ? 3'h3 : 3'h0)) begin
        cnt <= 3'h0;
        slow <= !slow;
        fl_ack <= 1'b1;
        fl_rdata <= mem[fl_addr];
        if (fl_op == FL_WRITE) mem[fl_addr] <= fl_wdata;
        if (fl_op == FL_ERASE) for (int i = 0; i < 2**AW; i++) mem[i] <= ERASED;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_flash_program_mode_control.sv ***
`default_nettype none
module tb_flash_program_mode_control
  import fpmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_KEY = {IDX_KEY, 2'b00};
  localparam logic [17:0] A_ST  = {IDX_STAT, 2'b00};
  localparam logic [17:0] A_MPC = {IDX_MPC, 2'b00};
  localparam logic [17:0] A_SET = {IDX_SET, 2'b00};
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  logic [17:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]      s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]       s_axi_wstrb = 4'hF, cmd_addr = '0, fl_addr;
  logic [1:0]       s_axi_bresp, s_axi_rresp, self_mode, rr;
  logic             s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic             s_axi_bready = 1, s_axi_rready = 1, rx_fall = 0;
  logic             program_enable_pin = 0, fw_active = 0, cmd_valid = 0, dat_valid = 0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic             cmd_ready, dat_ready, rsp_valid, rsp_ack, fl_req, fl_ack, flash_wr_enable;
  logic [7:0]       cmd_code = '0, cmd_data = '0, dat_byte = '0, rsp_data, fl_wdata, fl_rdata, rb;
  logic [4:0]       cmd_len = '0;
  logic [15:0]      bit_period;
  fpmc_flop_t       fl_op;
  fpmc_link_t       link_mode;
  int               errors = 0, checks_done = 0;
  logic [7:0]       q [$];
  logic [7:0]       tc [7] = '{8'hEE, C_STATUS, C_OSC, C_ETIME, C_WTIME, C_BAUD, C_BAUD};
  logic [7:0]       td [7] = '{0, 0, 8'h21, 8'h22, 8'h23, 8'h05, 8'h06};
  logic [0:6]       ta = 7'b0111100;
  always #2 clk_sys = ~clk_sys;
  fpmc_top #(.FLASH_AW(4), .PERIPH_KHZ(2500), .SIG_BYTE(8'h3E)) dut_u ( // arbitrary signature
    .clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .program_enable_pin, .fw_active, .rx_fall, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_addr, .cmd_len, .cmd_data, .dat_valid, .dat_ready, .dat_byte, .rsp_valid,
    .rsp_ack, .rsp_data, .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_rdata, .fl_ack,
    .flash_wr_enable, .self_mode, .link_mode, .bit_period);
  fpmc_flash_model #(.AW(4)) flm (.clk_sys, .srst, .fl_req, .fl_op, .fl_addr, .fl_wdata,
    .fl_rdata, .fl_ack);
  // ====
  // tasks
  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %0s exp %h got %h", n, e, g);
    end
  endtask
  task ck1(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask
  task tmo(input int k);
    if (k >= 500) begin
      errors++;
      conclude();
    end
  endtask
  task wr(input logic [17:0] a, input logic [7:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    k = 0;
    do @(posedge clk_sys);
    while (s_axi_awready !== 1'b1 && ++k < 500);
    tmo(k);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    k = 0;
    do @(posedge clk_sys);
    while (s_axi_bvalid !== 1'b1 && ++k < 500);
    tmo(k);
    rr = s_axi_bresp;
  endtask
  task rd(input logic [17:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    k = 0;
    do @(posedge clk_sys);
    while (s_axi_arready !== 1'b1 && ++k < 500);
    tmo(k);
    s_axi_arvalid <= 1'b0;
    k = 0;
    do @(posedge clk_sys);
    while (s_axi_rvalid !== 1'b1 && ++k < 500);
    tmo(k);
    rb = s_axi_rdata[7:0];
    rr = s_axi_rresp;
  endtask
  task pr(input logic [7:0] v, input logic [7:0] e);
    wr(A_KEY, PROT_KEY);
    wr(A_MPC, v);
    wr(A_MPC, ~v);
    wr(A_MPC, v);
    rd(A_MPC);
    chk("mpc", e, rb);
  endtask
  task cmd(input logic [7:0] c, input logic [3:0] a, input logic e);
    int k;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_len <= 5'h01;
    cmd_data <= td[a];
    cmd_valid <= 1'b1;
    k = 0;
    do @(posedge clk_sys);
    while (cmd_ready !== 1'b1 && ++k < 500);
    tmo(k);
    cmd_valid <= 1'b0;
    dat_valid <= q.size() > 0;
    if (q.size() > 0) dat_byte <= q[0];
    k = 0;
    do begin
      @(posedge clk_sys);
      if (dat_valid && dat_ready === 1'b1) begin
        void'(q.pop_front());
        dat_valid <= q.size() > 0;
        if (q.size() > 0) dat_byte <= q[0];
      end
    end while (rsp_valid !== 1'b1 && ++k < 500);
    tmo(k);
    ck1("ack", e, rsp_ack);
  endtask
  // ====
  // tests
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rd(A_MPC);
    chk("mpc", 8'h08, rb);
    rd(18'h00000);
    chk("resp", {6'h0, AXI_SLVERR}, {6'h0, rr});
    wr(18'h00000, 8'h00);
    chk("bresp", {6'h0, AXI_SLVERR}, {6'h0, rr});
    wr(A_MPC, 8'h00);
    rd(A_MPC);
    chk("mpc", 8'h08, rb);
    rd(A_ST);
    chk("err", 8'h01, rb);
    wr(A_ST, 8'h00);
    rd(A_ST);
    chk("err", 8'h00, rb);
    pr(8'h01, 8'h01);
    chk("mode", 8'h01, {6'h0, self_mode});
    pr(8'h03, 8'h01);
    fw_active <= 1'b1;
    pr(8'hF3, 8'h03);
    fw_active <= 1'b0;
    pr(8'h02, 8'h03);
    pr(8'h01, 8'h01);
    ck1("wr_en", 1'b0, flash_wr_enable);
    $display("test protect done");
    repeat (8) begin
      program_enable_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      program_enable_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    cmd(C_RESET, 4'h0, 1'b1);
    chk("link", {6'h0, LNK_CSI}, {6'h0, link_mode});
    program_enable_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(A_MPC);
    chk("mpc", 8'h05, rb);
    ck1("wr_en", 1'b1, flash_wr_enable);
    for (int i = 0; i < 7; i++) cmd(tc[i], 4'(i), ta[i]);
    rd(A_SET);
    chk("osc", 8'h21, rb);
    chk("wtime", 8'h23, s_axi_rdata[23:16]);
    chk("baud", 8'h00, s_axi_rdata[31:24]);
    cmd(C_SIG, 4'h0, 1'b1);
    chk("sig", 8'h3E, rsp_data);
    $display("test commands done");
    cmd(C_BLANK, 4'h0, 1'b0);
    cmd(C_ERASE, 4'h0, 1'b1);
    cmd(C_BLANK, 4'h0, 1'b1);
    q = '{8'h3C};
    cmd(C_WRITE, 4'h3, 1'b1);
    q = '{8'h3D};
    cmd(C_SUCC, 4'h0, 1'b1);
    chk("cell", 8'h3D, flm.mem[4]);
    for (int i = 0; i < 16; i++) q.push_back(i == 3 ? 8'h3C : i == 4 ? 8'h3D : 8'hFF);
    cmd(C_VERIFY, 4'h0, 1'b1);
    pr(8'h09, 8'h0D);
    cmd(C_ERASE, 4'h0, 1'b0);
    $display("test flash done");
    srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rd(A_MPC);
    chk("mpc", 8'h0C, rb);
    repeat (2) begin
      rx_fall <= 1'b1;
      @(posedge clk_sys);
      rx_fall <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
    cmd(C_RESET, 4'h0, 1'b1);
    chk("period", 8'h06, bit_period[7:0]);
    chk("link", {6'h0, LNK_UART}, {6'h0, link_mode});
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
